// ---- hdl/asf_formatter.sv ----
// Converter result formatter: turns digit strobes into serial words,
// steers parity from polarity, and takes run/hold commands.
// Assumes all inputs synchronous to clk_sys and an APB master.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: Every strobe loads one word to transmitter
// RULE2: Upper nibble digit code, lower nibble BCD
// RULE3: Polarity drives transmitter even parity select
// RULE4: Receiver decodes parity flag as positive sign
// RULE5: Received start word begins new measurement
// RULE6: Busy assertion clears receiver data-ready flag
// RULE7: Flags ride top word's upper BCD bits
// RULE8: Bit clock finishes word before next strobe
// RULE9: Transmitter latches parity at word load
// RULE10: Wide host reads all; narrow uses mux
// RULE11: Host can start or hold measurement
// RULE12: Converter clock supplied from outside
// RULE13: Converter clock 120kHz or 12kHz
// RULE14: Display blanks four digits on over-range
// RULE15: BCD valid together with its digit select
// RULE16: Three-and-half mode outputs LEAST_SIGNIFICANT_DIGIT as zero
// RULE17: Strobe into full holding register flags overrun
module asf_formatter (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side
    input wire asf_pkg::asf_conv_t conv_i,
    input wire logic strobe,
    input wire logic busy,
    output logic run_hold,
    output logic conv_start,
    // Transmitter side
    input wire logic tx_empty,
    output asf_pkg::asf_word_t tx_word,
    output logic tx_load,
    output logic even_parity_select,
    // Receiver side
    input wire logic [7:0] serial_receive_input,
    input wire logic rx_ready,
    output logic data_ready_clear,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic [2:0] rise; // Strobe, busy, receive-ready edges
    logic str_rise;
    logic busy_rise;
    logic rx_rise;

    asf_rise #(.W(3)) u_rise (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .din({strobe, busy, rx_ready}),
        .rise(rise)
    );

    // Gate with the enable so a frozen cycle triggers nothing
    assign str_rise = ce & rise[2];
    assign busy_rise = ce & rise[1];
    assign rx_rise = ce & rise[0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Declared ahead of its users so the widths below resolve
    localparam int IRQ_W_L = asf_pkg::IRQ_W;
    logic [3:0] ctrl_q; // Run, start, flag mux, mode
    logic [IRQ_W_L-1:0] irq_stat_q; // Sticky events
    logic [IRQ_W_L-1:0] irq_mask_q; // Enables
    asf_pkg::asf_word_t tx_word_q; // Word held for transmitter
    logic tx_load_q; // One-cycle load pulse
    logic parity_q; // Polarity captured with the word
    logic start_q; // One-cycle start pulse
    logic drc_q; // One-cycle data-ready clear
    logic [11:0] reading_q; // Wide-host snapshot
    logic [31:0] prdata_q; // Read data, taken in setup

    // ------------------------------------------------------------
    // Word formation
    // ------------------------------------------------------------
    logic [3:0] sel_code; // Digit code for the active select
    logic is_top;
    logic is_lsd;
    logic [3:0] bcd_eff; // BCD after LEAST_SIGNIFICANT_DIGIT blanking and flag mux

    assign is_top = conv_i.digit[4];
    assign is_lsd = conv_i.digit[0];
    // Priority encode the one-hot select into the word code [RULE2]
    assign sel_code = is_top ? asf_pkg::SEL_TOP :
                      conv_i.digit[3] ? asf_pkg::SEL_D4 :
                      conv_i.digit[2] ? asf_pkg::SEL_D3 :
                      conv_i.digit[1] ? asf_pkg::SEL_D2 :
                      asf_pkg::SEL_D1;
    // Short mode has no LEAST_SIGNIFICANT_DIGIT count, so force it to zero [RULE16]
    // Top digit's upper bits are always zero, so flags can ride them
    assign bcd_eff =
        (is_lsd && ctrl_q[asf_pkg::CTRL_MODE3]) ? 4'h0 :
        (is_top && ctrl_q[asf_pkg::CTRL_FLAG_MUX]) ?
            {conv_i.polarity, conv_i.over_range, conv_i.under_range,
             conv_i.bcd[0]} :
        conv_i.bcd;

    // ------------------------------------------------------------
    // Receive command decode
    // ------------------------------------------------------------
    logic cmd_start;
    logic cmd_hold;

    assign cmd_start = rx_rise && serial_receive_input == asf_pkg::CMD_START;
    assign cmd_hold = rx_rise && serial_receive_input == asf_pkg::CMD_HOLD;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic setup;
    logic wr;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_istat;
    logic hit_imask;
    logic hit_read;
    logic mapped;
    logic sw_start;
    logic [IRQ_W_L-1:0] events;
    logic [IRQ_W_L-1:0] clr;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & ce;
    assign hit_ctrl = paddr == asf_pkg::REG_CTRL;
    assign hit_stat = paddr == asf_pkg::REG_STATUS;
    assign hit_istat = paddr == asf_pkg::REG_IRQ_STAT;
    assign hit_imask = paddr == asf_pkg::REG_IRQ_MASK;
    assign hit_read = paddr == asf_pkg::REG_READING;
    assign mapped = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_read;
    assign sw_start = wr && hit_ctrl && pwdata[asf_pkg::CTRL_START];
    assign clr = (wr && hit_istat) ? pwdata[IRQ_W_L-1:0] : '0;

    // Zero-wait access; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;

    // Event vector for the sticky status
    assign events = {busy_rise,
                     str_rise & ~tx_empty,
                     str_rise & is_lsd,
                     str_rise & tx_empty};

    // ------------------------------------------------------------
    // Control register and run/hold
    // ------------------------------------------------------------
    // Bus write first, then a received command takes priority [RULE11]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ctrl_q <= asf_pkg::CTRL_RESET;
        else if (ce)
        begin
            if (wr && hit_ctrl)
                ctrl_q <= {pwdata[3:2], 1'b0, pwdata[0]};
            if (cmd_start)
                ctrl_q[asf_pkg::CTRL_RUN] <= 1'b1; // [RULE5]
            else if (cmd_hold)
                ctrl_q[asf_pkg::CTRL_RUN] <= 1'b0; // [RULE11]
        end
    end

    // Start pulse from the line or from software [RULE5] [RULE11]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            start_q <= 1'b0;
        else if (ce)
            start_q <= cmd_start | sw_start;
    end

    // Busy edge clears the receiver's ready flag [RULE6]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            drc_q <= 1'b0;
        else if (ce)
            drc_q <= busy_rise;
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    // One word per strobe; select and BCD latched together [RULE1]
    // Load is still issued when full; the overrun flag records it
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tx_word_q <= '0;
            tx_load_q <= 1'b0;
            parity_q <= 1'b0;
        end
        else if (ce)
        begin
            tx_load_q <= str_rise; // [RULE1]
            if (str_rise)
            begin
                tx_word_q <= {sel_code, bcd_eff}; // [RULE2] [RULE15]
                parity_q <= conv_i.polarity; // [RULE3]
            end
        end
    end

    // Snapshot for a wide host: flags, BCD and digit selects
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reading_q <= '0;
        else if (ce && str_rise)
            reading_q <= {conv_i.polarity, conv_i.over_range,
                          conv_i.under_range, conv_i.bcd, conv_i.digit};
    end

    // ------------------------------------------------------------
    // Interrupts: set wins over a same-cycle clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end
        else if (ce)
        begin
            irq_stat_q <= (irq_stat_q & ~clr) | events; // [RULE17]
            if (wr && hit_imask)
                irq_mask_q <= pwdata[IRQ_W_L-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    assign rd_mux =
        hit_ctrl ? {28'h000_0000, ctrl_q} :
        hit_stat ? {28'h000_0000, busy, tx_empty, rx_ready, tx_load_q} :
        hit_istat ? {28'h000_0000, irq_stat_q} :
        hit_imask ? {28'h000_0000, irq_mask_q} :
        hit_read ? {20'h0_0000, reading_q} :
        32'h0000_0000;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            prdata_q <= '0;
        else if (ce && setup)
            prdata_q <= rd_mux;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign run_hold = ctrl_q[asf_pkg::CTRL_RUN];
    assign conv_start = start_q;
    assign tx_word = tx_word_q;
    assign tx_load = tx_load_q;
    assign even_parity_select = parity_q;
    assign data_ready_clear = drc_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_strobe_loads: assert property (@(posedge clk_sys) disable iff (!rst_n)
        str_rise |=> tx_load_q ##1 (!tx_load_q || !ce || $rose(strobe)))
        else $error("strobe did not give one load"); // [RULE1]

    a_top_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (str_rise && is_top) |=> tx_word_q.sel == asf_pkg::SEL_TOP)
        else $error("top digit code wrong"); // [RULE2]

    a_parity_sign: assert property (@(posedge clk_sys) disable iff (!rst_n)
        str_rise |=> even_parity_select == $past(conv_i.polarity))
        else $error("parity select not polarity"); // [RULE3]

    a_start_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_start |=> conv_start && run_hold)
        else $error("start command ignored"); // [RULE5]

    a_busy_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busy_rise |=> data_ready_clear)
        else $error("busy did not clear data ready"); // [RULE6]

    a_hold_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_hold && !cmd_start) |=> !run_hold)
        else $error("hold command ignored"); // [RULE11]

    a_bcd_with_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (str_rise && !is_lsd && !is_top) |=>
            tx_word_q.bcd == $past(conv_i.bcd))
        else $error("bcd not latched with select"); // [RULE15]

    a_lsd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (str_rise && is_lsd && ctrl_q[asf_pkg::CTRL_MODE3])
            |=> tx_word_q.bcd == 4'h0)
        else $error("short mode LEAST_SIGNIFICANT_DIGIT not zero"); // [RULE16]

endmodule : asf_formatter

`default_nettype wire

// ---- include/asf_pkg.sv ----
// Shared constants and carrier types for the converter result formatter.
// Assumes a single 20 MHz system clock and an APB register bus.
package asf_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00; // Run, start, flag mux
    localparam logic [7:0] REG_STATUS = 8'h04; // Live state, read only
    localparam logic [7:0] REG_IRQ_STAT = 8'h08; // Sticky events, W1C
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C; // Interrupt enables
    localparam logic [7:0] REG_READING = 8'h10; // Wide-host snapshot

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0; // Level: run (1) or hold (0)
    localparam int CTRL_START = 1; // Write 1: start pulse
    localparam int CTRL_FLAG_MUX = 2; // Put flags on top word
    localparam int CTRL_MODE3 = 3; // Three-and-a-half digit mode
    localparam logic [3:0] CTRL_RESET = 4'h1; // Running after reset

    // ------------------------------------------------------------
    // Interrupt event bits
    // ------------------------------------------------------------
    localparam int IRQ_WORD = 0; // Word handed to an empty transmitter
    localparam int IRQ_DONE = 1; // Last word of a reading sent
    localparam int IRQ_OVERRUN = 2; // Strobe while holding reg full
    localparam int IRQ_BUSY = 3; // Measurement has begun
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------
    // Digit-select codes, upper nibble of each word
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_TOP = 4'h0;
    localparam logic [3:0] SEL_D4 = 4'h8;
    localparam logic [3:0] SEL_D3 = 4'h4;
    localparam logic [3:0] SEL_D2 = 4'h2;
    localparam logic [3:0] SEL_D1 = 4'h1;

    // Received command words
    localparam logic [7:0] CMD_START = 8'h53; // Begin a measurement
    localparam logic [7:0] CMD_HOLD = 8'h48; // Hold the measurement

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Converter outputs; digit[4] is the top digit, digit[0] the LEAST_SIGNIFICANT_DIGIT
    typedef struct packed {
        logic [4:0] digit;
        logic [3:0] bcd;
        logic polarity;
        logic over_range;
        logic under_range;
    } asf_conv_t;

    // Word for the serial transmitter
    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] bcd;
    } asf_word_t;

endpackage : asf_pkg

// ---- hdl/asf_rise.sv ----
// Rising-edge detector bank for synchronous level inputs.
// Assumes inputs are already synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none

module asf_rise #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Levels in, edges out
    input wire logic [W-1:0] din,
    output logic [W-1:0] rise
);

    // Previous sample; frozen with the enable so no edge is lost
    logic [W-1:0] prev_q;

    // ------------------------------------------------------------
    // Sample history
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            prev_q <= '0;
        else if (ce)
            prev_q <= din;
    end

    // Edge is high for the cycle in which the level first appears
    assign rise = din & ~prev_q;

endmodule : asf_rise

`default_nettype wire

// ---- verification/asf_uart_model.sv ----
// Far-side model: transmitter holding register plus an odd-checking
// receiver. Assumes tx_load is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
`default_nettype none

module asf_uart_model #(
    parameter int FAST = 4,
    parameter int SLOW = 40
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench control: long shift time
    input wire logic slow,
    // Formatter transmit side
    input wire logic tx_load,
    input wire asf_pkg::asf_word_t tx_word,
    input wire logic even_parity_select,
    output logic tx_empty,
    // Sign decoded by the receiver from the last word
    output logic sign_q
);
    // ------------------------------------------------------------
    // Holding register and receiver
    // ------------------------------------------------------------
    int cnt_q; // Bit times left in the shift
    logic pbit; // Parity bit as sent
    // Parity follows the select seen at load time
    assign pbit = even_parity_select ? ^tx_word : ~^tx_word;
    // Busy until the word is shifted out, so a fast strobe overruns
    assign tx_empty = (cnt_q == 0);
    // Load starts the shift; the receiver judges parity at once
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_q <= 0;
            sign_q <= 1'b0;
        end
        else if (tx_load)
        begin
            cnt_q <= slow ? SLOW : FAST;
            // Parity error with odd checking reads as positive
            sign_q <= ~(^tx_word ^ pbit);
        end
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
endmodule : asf_uart_model
`default_nettype wire

// ---- verification/asf_formatter_tb_top.sv ----
// Self-checking bench for the result formatter.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none

module asf_formatter_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, serial_receive_input = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err, strobe = 1'b0, busy = 1'b0;
    logic rx_ready = 1'b0, run_hold, conv_start, tx_empty, tx_load;
    logic even_parity_select, data_ready_clear, irq, sign_q;
    logic pol, ovr, und;
    asf_pkg::asf_conv_t conv_i = '0;
    asf_pkg::asf_word_t tx_word;
    logic [31:0] seed = 32'h0000_005C; // Fixed start of the xorshift
    logic [3:0] sel_tab [5] = '{asf_pkg::SEL_D1, asf_pkg::SEL_D2,
        asf_pkg::SEL_D3, asf_pkg::SEL_D4, asf_pkg::SEL_TOP};
    int bad_count = 0, checked = 0, cyc = 0, starts = 0, clears = 0;

    asf_formatter asf_formatter_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_i(conv_i),
        .strobe(strobe), .busy(busy), .run_hold(run_hold),
        .conv_start(conv_start), .tx_empty(tx_empty), .tx_word(tx_word),
        .tx_load(tx_load), .even_parity_select(even_parity_select),
        .serial_receive_input(serial_receive_input),
        .rx_ready(rx_ready), .data_ready_clear(data_ready_clear),
        .irq(irq));
    asf_uart_model asf_uart_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .slow(slow), .tx_load(tx_load), .tx_word(tx_word),
        .even_parity_select(even_parity_select), .tx_empty(tx_empty),
        .sign_q(sign_q));

    // Clock, pulse counters and hang guard
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        starts += (conv_start === 1'b1);
        clears += (data_ready_clear === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Word the transmitter should get for one digit
    function automatic logic [31:0] exp_word(int i, logic [3:0] b,
        logic mux, logic m3);
        logic [3:0] v;
        v = b;
        if (i == 4 && mux)
            v = {pol, ovr, und, b[0]};
        if (i == 0 && m3)
            v = 4'h0;
        return {24'h0000_00, sel_tab[i], v};
    endfunction : exp_word

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask : chk_b

    // One APB transfer; waits for pready at an access edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Present one digit, strobe it and check the word that follows
    task automatic digit(input int i, input logic [3:0] b,
        input logic mux, input logic m3, input logic wait_empty);
        int n;
        @(posedge clk_sys);
        conv_i <= '{digit: 5'h01 << i, bcd: b, polarity: pol,
            over_range: ovr, under_range: und};
        strobe <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (tx_load !== 1'b1 && n < 8);
        chk_w({24'h0000_00, tx_word}, exp_word(i, b, mux, m3));
        chk_b(even_parity_select, pol);
        @(posedge clk_sys);
        strobe <= 1'b0;
        #1;
        chk_b(sign_q, pol);
        n = 0;
        while (wait_empty && tx_empty !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask : digit

    // Received command word; counts start pulses it causes
    task automatic cmd(input logic [7:0] w, input logic run, input int st);
        int s0;
        s0 = starts;
        @(posedge clk_sys);
        serial_receive_input <= w;
        rx_ready <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk_w(starts - s0, st);
        chk_b(run_hold, run);
        @(posedge clk_sys);
        rx_ready <= 1'b0;
    endtask : cmd

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [3:0] b;
        int s0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        apb(1'b0, asf_pkg::REG_CTRL, 0);
        chk_w(q, {28'h0, asf_pkg::CTRL_RESET});
        apb(1'b0, asf_pkg::REG_IRQ_MASK, 0);
        chk_w(q, 0);
        apb(1'b0, 8'h14, 0);
        chk_w({q[30:0], err}, 1);
        // Full readings in every mode with random digits
        for (int m = 0; m < 4; m++)
        begin
            {pol, ovr, und} = xs();
            apb(1'b1, asf_pkg::REG_CTRL, {m, 2'b01});
            for (int i = 4; i >= 0; i--)
            begin
                b = (i == 4) ? {3'b000, xs() & 1} : xs() % 10;
                digit(i, b, m[0], m[1], 1'b1);
            end
            apb(1'b0, asf_pkg::REG_READING, 0);
            chk_w(q, {20'h0, pol, ovr, und, b, 5'h01});
            apb(1'b0, asf_pkg::REG_IRQ_STAT, 0);
            chk_w(q, 32'h0000_0003);
            apb(1'b1, asf_pkg::REG_IRQ_STAT, 32'h0000_000F);
        end
        // Strobe into a full holding register
        slow <= 1'b1;
        digit(3, 4'h7, 1'b0, 1'b0, 1'b0);
        digit(3, 4'h2, 1'b0, 1'b0, 1'b0);
        apb(1'b0, asf_pkg::REG_IRQ_STAT, 0);
        chk_w(q, 32'h0000_0005);
        apb(1'b1, asf_pkg::REG_IRQ_MASK, 32'h0000_0004);
        #1;
        chk_b(irq, 1'b1);
        apb(1'b1, asf_pkg::REG_IRQ_STAT, 32'h0000_0005);
        #1;
        chk_b(irq, 1'b0);
        slow <= 1'b0;
        // Commands over the serial input, then over APB
        cmd(asf_pkg::CMD_HOLD, 1'b0, 0);
        cmd(8'h00, 1'b0, 0);
        cmd(asf_pkg::CMD_START, 1'b1, 1);
        apb(1'b1, asf_pkg::REG_CTRL, 0);
        #1;
        chk_b(run_hold, 1'b0);
        s0 = starts;
        apb(1'b1, asf_pkg::REG_CTRL, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        chk_w(starts - s0, 1);
        // Busy held high clears data ready exactly once
        s0 = clears;
        busy <= 1'b1;
        repeat (6) @(posedge clk_sys);
        busy <= 1'b0;
        chk_w(clears - s0, 1);
        apb(1'b0, asf_pkg::REG_IRQ_STAT, 0);
        chk_w(q, 32'h0000_0008);
        end_of_test();
    end
endmodule : asf_formatter_tb_top
`default_nettype wire
